// *** dual_image_boot_sequencer.sv ***
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "boot_seq_map.svh"
module dual_image_boot_sequencer #(
    parameter int STEP_CYC = `STEP_CYC,
    parameter int HB_CYC = `HB_CYC,
    parameter int APP_TICKS = `APP_TICKS,
    parameter bit APP_IMAGE = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic upd_error,
    output boot_seq_pkg::upd_type upd,
    output logic [3:0] led,
    output logic irq
);
    // The heartbeat must be visibly faster than the step rate
    if (STEP_CYC < 2 || HB_CYC < 1 || HB_CYC >= STEP_CYC) begin : g_bad_t
        $error("Step and heartbeat periods cannot be served");
    end
    if (APP_TICKS < 1 || APP_TICKS > 255) begin : g_bad_a
        $error("APP_TICKS must lie in 1..255");
    end

    boot_seq_pkg::core_type s_r;
    boot_seq_pkg::core_type s_nxt;
    logic step_tick;
    logic hb_tick;

    // Number shown on the state LEDs
    function automatic logic [2:0] state_num(
        input boot_seq_pkg::state_type st
    );
        case (st)
            boot_seq_pkg::ST_RESET: state_num = 3'h0;
            boot_seq_pkg::ST_RELEASE: state_num = 3'h1;
            boot_seq_pkg::ST_EMPTY: state_num = 3'h2;
            boot_seq_pkg::ST_APPSEL: state_num = 3'h3;
            boot_seq_pkg::ST_ADDR: state_num = 3'h4;
            boot_seq_pkg::ST_WDOG: state_num = 3'h5;
            boot_seq_pkg::ST_BOOT: state_num = 3'h6;
            default: state_num = 3'h7;
        endcase
    endfunction

    // Byte-lane merge of a write into a register of up to 32 bits
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // Step pacing, so every state stays visible long enough
    tick_divider #(
        .DIV(STEP_CYC)
    ) u_step (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(step_tick)
    );

    // Heartbeat rate, independent of the state machine
    tick_divider #(
        .DIV(HB_CYC)
    ) u_hb (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(hb_tick)
    );

    // Next-state logic for bus slave, registers and sequencer
    always_comb begin
        logic [2:0] set;
        logic [2:0] clr;
        logic adv;
        logic do_wr;
        logic [31:0] mg;
        set = 3'h0;
        clr = 3'h0;
        mg = 32'h0;
        s_nxt = s_r;
        s_nxt.upd.wr = 1'b0;
        adv = step_tick && s_r.ctrl[`CTRL_RUN];

        // Address and data may arrive in either order
        if (s_r.awready && s_axi_awvalid) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.awaddr = s_axi_awaddr[4:0];
        end
        if (s_r.wready && s_axi_wvalid) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        do_wr = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
        if (do_wr) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = 2'h0;
            case (s_r.awaddr)
                `CTRL_OFS: begin
                    mg = merge({30'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb);
                    s_nxt.ctrl = mg[1:0];
                end
                `IRQ_STAT_OFS: begin
                    if (s_r.wstrb[0]) begin
                        clr = s_r.wdata[2:0];
                    end
                end
                `IRQ_MASK_OFS: begin
                    mg = merge({29'h0, s_r.irq_mask}, s_r.wdata, s_r.wstrb);
                    s_nxt.irq_mask = mg[2:0];
                end
                `ADDR_OFS: begin
                    mg = merge({8'h0, s_r.app_addr}, s_r.wdata, s_r.wstrb);
                    s_nxt.app_addr = mg[23:0];
                end
                `STAT_OFS: ;
                default: s_nxt.bresp = 2'h2;
            endcase
        end

        // One read in flight; answer one cycle after the address
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_r.arready && s_axi_arvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = 2'h0;
            case (s_axi_araddr[4:0])
                `CTRL_OFS: s_nxt.rdata = {30'h0, s_r.ctrl};
                `STAT_OFS: s_nxt.rdata = {24'h0, s_r.upd.reconfig,
                    s_r.st == boot_seq_pkg::ST_APP,
                    s_r.st == boot_seq_pkg::ST_HOLD,
                    2'h0, state_num(s_r.st)};
                `IRQ_STAT_OFS: s_nxt.rdata = {29'h0, s_r.irq_stat};
                `IRQ_MASK_OFS: s_nxt.rdata = {29'h0, s_r.irq_mask};
                `ADDR_OFS: s_nxt.rdata = {8'h0, s_r.app_addr};
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = 2'h2;
                end
            endcase
        end

        // Heartbeat runs regardless of state
        if (hb_tick) begin
            s_nxt.hb = ~s_r.hb;
        end

        // Boot sequence; a state's action fires on leaving it
        case (s_r.st)
            boot_seq_pkg::ST_RESET: begin
                s_nxt.upd.rst = 1'b1;
                s_nxt.upd.reconfig = 1'b0;
                if (adv) begin
                    if (s_r.ctrl[`CTRL_APP]) begin
                        s_nxt.st = boot_seq_pkg::ST_APP;
                        s_nxt.app_cnt = 8'h0;
                        s_nxt.blink = 1'b0;
                    end else begin
                        // Release lands with the state change, not later
                        s_nxt.upd.rst = 1'b0;
                        s_nxt.st = boot_seq_pkg::ST_RELEASE;
                    end
                end
            end
            boot_seq_pkg::ST_RELEASE: begin
                s_nxt.upd.rst = 1'b0;
                if (adv) begin
                    s_nxt.st = boot_seq_pkg::ST_EMPTY;
                end
            end
            boot_seq_pkg::ST_EMPTY: begin
                // No action here
                if (adv) begin
                    s_nxt.st = boot_seq_pkg::ST_APPSEL;
                end
            end
            boot_seq_pkg::ST_APPSEL: begin
                if (adv) begin
                    s_nxt.upd.app_sel = 1'b1;
                    s_nxt.upd.wr = 1'b1;
                    s_nxt.upd.param = `PRM_APP_SEL;
                    s_nxt.upd.data = 24'h1;
                    s_nxt.st = boot_seq_pkg::ST_ADDR;
                end
            end
            boot_seq_pkg::ST_ADDR: begin
                if (adv) begin
                    s_nxt.upd.wr = 1'b1;
                    s_nxt.upd.param = `PRM_ADDR;
                    s_nxt.upd.data = s_r.app_addr;
                    s_nxt.st = boot_seq_pkg::ST_WDOG;
                end
            end
            boot_seq_pkg::ST_WDOG: begin
                if (adv) begin
                    s_nxt.upd.wr = 1'b1;
                    s_nxt.upd.param = `PRM_WDOG;
                    s_nxt.upd.data = 24'h0;
                    s_nxt.upd.reconfig = 1'b1;
                    s_nxt.st = boot_seq_pkg::ST_BOOT;
                    set[`IRQ_BOOT] = 1'b1;
                end
            end
            boot_seq_pkg::ST_BOOT: begin
                // Trigger stays high until the device reloads or an updater error parks the sequencer
                s_nxt.upd.reconfig = 1'b1;
            end
            boot_seq_pkg::ST_HOLD: begin
                // Only reset leaves this state
                s_nxt.st = boot_seq_pkg::ST_HOLD;
            end
            boot_seq_pkg::ST_APP: begin
                if (hb_tick) begin
                    s_nxt.blink = ~s_r.blink;
                end
                if (step_tick) begin
                    s_nxt.app_cnt = s_r.app_cnt + 8'h1;
                    if (s_r.app_cnt == 8'(APP_TICKS - 1)) begin
                        s_nxt.st = boot_seq_pkg::ST_RESET;
                        s_nxt.ctrl[`CTRL_APP] = 1'b0;
                        s_nxt.blink = 1'b0;
                        set[`IRQ_APP] = 1'b1;
                    end
                end
            end
            default: s_nxt.st = boot_seq_pkg::ST_HOLD;
        endcase

        // Updater error during the write phase parks the sequencer
        if (upd_error && (s_r.st == boot_seq_pkg::ST_APPSEL ||
                s_r.st == boot_seq_pkg::ST_ADDR ||
                s_r.st == boot_seq_pkg::ST_WDOG ||
                s_r.st == boot_seq_pkg::ST_BOOT)) begin
            s_nxt.st = boot_seq_pkg::ST_HOLD;
            s_nxt.upd.wr = 1'b0;
            s_nxt.upd.reconfig = 1'b0;
            set[`IRQ_ERR] = 1'b1;
        end

        // A new event wins over a clear in the same cycle
        s_nxt.irq_stat = (s_r.irq_stat & ~clr) | set;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // LEDs follow the state being entered
        if (s_nxt.st == boot_seq_pkg::ST_APP) begin
            s_nxt.led = {s_nxt.hb, {3{s_nxt.blink}}};
        end else begin
            s_nxt.led = {s_nxt.hb, state_num(s_nxt.st)};
        end

        // Ready only while the holding slot is free
        s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_ok && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
    end

    // State register; reset parks the updater in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.upd.rst <= 1'b1;
            s_r.ctrl <= {APP_IMAGE, 1'b1};
            s_r.app_addr <= `ADDR_RST;
            s_r.irq_mask <= `MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign upd = s_r.upd;
    assign led = s_r.led;
    assign irq = s_r.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_release_after_reset: assert property (
        $past(s_r.st) == boot_seq_pkg::ST_RESET &&
        s_r.st == boot_seq_pkg::ST_RELEASE |-> !s_r.upd.rst)
        else $error("Updater reset not released");
    a_empty_order: assert property (
        $changed(s_r.st) && s_r.st == boot_seq_pkg::ST_EMPTY
        |-> $past(s_r.st) == boot_seq_pkg::ST_RELEASE)
        else $error("Empty state out of order");
    a_select_write: assert property (
        $changed(s_r.st) && s_r.st == boot_seq_pkg::ST_ADDR
        |-> s_r.upd.app_sel && s_r.upd.wr &&
        s_r.upd.param == `PRM_APP_SEL ##1 !s_r.upd.wr)
        else $error("Select flag write wrong");
    a_wdog_write: assert property (
        $changed(s_r.st) && s_r.st == boot_seq_pkg::ST_BOOT
        |-> s_r.upd.wr && s_r.upd.param == `PRM_WDOG)
        else $error("Watchdog disable write missing");
    a_boot_trigger: assert property (
        s_r.st == boot_seq_pkg::ST_BOOT |-> s_r.upd.reconfig)
        else $error("Reconfig trigger low in boot state");
    a_led_state: assert property (
        s_r.st != boot_seq_pkg::ST_APP
        |-> s_r.led[2:0] == state_num(s_r.st))
        else $error("State LEDs do not show the state");
    a_heartbeat_beat: assert property (
        hb_tick |=> s_r.led[3] != $past(s_r.led[3]))
        else $error("Heartbeat did not toggle");
    a_hold_sticky: assert property (
        s_r.st == boot_seq_pkg::ST_HOLD |=> s_r.st == boot_seq_pkg::ST_HOLD)
        else $error("Left hold state without reset");
    a_hold_cause: assert property (
        $changed(s_r.st) && s_r.st == boot_seq_pkg::ST_HOLD
        |-> $past(upd_error))
        else $error("Hold entered without error");
    a_app_leds: assert property (
        s_r.st == boot_seq_pkg::ST_APP
        |-> s_r.led[2:0] == 3'h0 || s_r.led[2:0] == 3'h7)
        else $error("Application LEDs not blinking together");
    a_step_paced: assert property (
        $changed(s_r.st) && ($past(s_r.st) == boot_seq_pkg::ST_RELEASE ||
        $past(s_r.st) == boot_seq_pkg::ST_EMPTY) |-> $past(step_tick))
        else $error("State advanced without a step tick");

    c_boot_reached: cover property (
        s_r.st == boot_seq_pkg::ST_WDOG ##1 s_r.st == boot_seq_pkg::ST_BOOT);
    c_hold_reached: cover property (
        $changed(s_r.st) && s_r.st == boot_seq_pkg::ST_HOLD);
    c_app_return: cover property (
        s_r.st == boot_seq_pkg::ST_APP ##1 s_r.st == boot_seq_pkg::ST_RESET);
endmodule

// *** boot_seq_map.svh ***
`ifndef BOOT_SEQ_MAP_SVH
`define BOOT_SEQ_MAP_SVH

// Register byte offsets
`define CTRL_OFS 5'h00
`define STAT_OFS 5'h04
`define IRQ_STAT_OFS 5'h08
`define IRQ_MASK_OFS 5'h0c
`define ADDR_OFS 5'h10

// Field positions
`define CTRL_RUN 0
`define CTRL_APP 1
`define IRQ_BOOT 0
`define IRQ_ERR 1
`define IRQ_APP 2

// Reset values
`define ADDR_RST 24'h400000
`define MASK_RST 3'h0

// Updater parameter codes
`define PRM_APP_SEL 3'h5
`define PRM_ADDR 3'h4
`define PRM_WDOG 3'h3

// Timing
`define CLK_MHZ 125
`define STEP_MS 1000
`define STEP_CYC (`STEP_MS * `CLK_MHZ * 1000)
`define HB_MS 100
`define HB_CYC (`HB_MS * `CLK_MHZ * 1000)
`define APP_S 7
`define APP_TICKS (`APP_S * 1000 / `STEP_MS)
`endif

// *** boot_seq_pkg.sv ***
package boot_seq_pkg;

    // Sequencer states, in their displayed order
    typedef enum logic [3:0] {
        ST_RESET, ST_RELEASE, ST_EMPTY, ST_APPSEL,
        ST_ADDR, ST_WDOG, ST_BOOT, ST_HOLD, ST_APP
    } state_type;

    // Port toward the remote update circuitry
    typedef struct packed {
        logic rst;
        logic app_sel;
        logic wr;
        logic [2:0] param;
        logic [23:0] data;
        logic reconfig;
    } upd_type;

    // Whole state of the sequencer and its bus slave
    typedef struct packed {
        state_type st;
        upd_type upd;
        logic [3:0] led;
        logic hb;
        logic blink;
        logic [7:0] app_cnt;
        logic [1:0] ctrl;
        logic [23:0] app_addr;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic awready;
        logic wready;
        logic aw_ok;
        logic w_ok;
        logic [4:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_type;

endpackage

// *** tick_divider.sv ***
`timescale 1ns/1ps
// Free-running divider giving a one-cycle enable every DIV cycles
module tick_divider #(
    parameter int DIV = 1000
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    if (DIV < 1) begin : g_bad
        $error("tick_divider: DIV must be at least 1");
    end

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_nxt;

    // Count to DIV-1, then wrap and pulse
    always_comb begin
        tick_nxt = (cnt_r == 32'(DIV - 1));
        cnt_nxt = tick_nxt ? 32'h0 : cnt_r + 32'h1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule

// *** upd_partner_model.sv ***
`timescale 1ns/1ps
`include "boot_seq_map.svh"
// Stand-in for the updater and the flash behind it
module upd_partner_model #(
    parameter logic [23:0] HALF = 24'h400000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire boot_seq_pkg::upd_type upd,
    input wire logic fault_arm,
    output logic upd_error,
    output logic boot_slot,
    output logic [23:0] boot_addr
);
    logic sel_r;
    logic [23:0] addr_r;

    // Latched words; select flag, address and error are forgotten while the updater is in reset
    always @(posedge aclk) begin
        if (!aresetn || upd.rst) begin
            sel_r <= 1'b0;
            addr_r <= 24'h0;
            upd_error <= 1'b0;
        end else begin
            if (upd.wr && upd.param == `PRM_APP_SEL) sel_r <= upd.data[0];
            if (upd.wr && upd.param == `PRM_ADDR) addr_r <= upd.data;
            // Faults only when the bench arms one, after the next word
            if (!fault_arm) upd_error <= 1'b0;
            else if (upd.wr) upd_error <= 1'b1;
        end
    end

    // Slot zero is the lower flash half, slot one the upper half
    always @(posedge aclk) begin
        if (!aresetn) begin
            boot_slot <= 1'b0;
            boot_addr <= 24'h0;
        end else if (upd.reconfig) begin
            boot_slot <= sel_r && (addr_r >= HALF);
            boot_addr <= sel_r ? addr_r : 24'h0;
        end
    end
endmodule

// *** dual_image_boot_sequencer_test.sv ***
`timescale 1ns/1ps
`include "boot_seq_map.svh"
module dual_image_boot_sequencer_test;
    localparam int STEP = 20;
    localparam int HB = 4;
    localparam int TICKS = 7;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, upd_error, irq;
    logic fault_arm, boot_slot, led_watch, hb_seen, hb_last;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] led;
    logic [2:0] led_last, l, prev;
    logic [23:0] boot_addr, app_addr;
    logic [33:0] r;
    logic [29:0] u;
    boot_seq_pkg::upd_type upd;
    int n_fail, check_count, seed, hb_gap, hb_toggles, led_gap, n, t0, bad;
    int flips;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [29:0] exp_u[$];
    logic [2:0] exp_led[$];

    dual_image_boot_sequencer #(.STEP_CYC(STEP), .HB_CYC(HB),
        .APP_TICKS(TICKS), .APP_IMAGE(1'b0)) dual_image_boot_sequencer_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .upd_error(upd_error), .upd(upd),
        .led(led), .irq(irq));

    upd_partner_model upd_partner_model_inst (.aclk(aclk),
        .aresetn(aresetn), .upd(upd), .fault_arm(fault_arm),
        .upd_error(upd_error), .boot_slot(boot_slot),
        .boot_addr(boot_addr));

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Write with both channels offered together; bready held until bvalid
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] e);
        @(posedge aclk);
        exp_b.push_back(e);
        awaddr <= {27'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] e);
        @(posedge aclk);
        exp_r.push_back({d, e});
        araddr <= {27'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    // Leaving the reset with the monitor of state changes paused
    task automatic do_reset;
        led_watch <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // Expected updater words and displayed states of a full boot run
    task automatic push_run(input logic [23:0] a);
        exp_u.push_back({3'd4, `PRM_APP_SEL, 24'h1});
        exp_u.push_back({3'd5, `PRM_ADDR, a});
        exp_u.push_back({3'd6, `PRM_WDOG, 24'h0});
        exp_led = {3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd6};
    endtask

    // Result watcher: takes the oldest note whenever an output appears
    always @(posedge aclk) begin
        if (bvalid && bready && exp_b.size() > 0)
            check("bresp", 32'(bresp), 32'(exp_b.pop_front()));
        if (rvalid && rready && exp_r.size() > 0) begin
            r = exp_r.pop_front();
            check("rdata", rdata, r[33:2]);
            check("rresp", 32'(rresp), 32'(r[1:0]));
        end
        if (upd.wr) begin
            u = exp_u.size() > 0 ? exp_u.pop_front() : '1;
            check("upd word", 32'({upd.param, upd.data}),
                32'(u[26:0]));
            check("upd state", 32'(led[2:0]), 32'(u[29:27]));
            check("select flag", 32'(upd.app_sel), 32'h1);
            check("trigger", 32'(upd.reconfig), 32'(u[29:27] == 3'd6));
        end
        led_gap++;
        if (led_watch && led[2:0] !== led_last) begin
            l = exp_led.size() > 0 ? exp_led.pop_front() : ~led[2:0];
            check("led state", 32'(led[2:0]), 32'(l));
            if (l != 3'd7 && l > 3'd1) begin
                check("step gap", led_gap, STEP);
            end
            led_gap = 0;
        end
        led_last = led[2:0];
        if (!aresetn) hb_seen = 1'b0;
        else if (led[3] !== hb_last) begin
            if (hb_seen) check("hb gap", hb_gap, HB);
            hb_seen = 1'b1;
            hb_gap = 1;
            hb_toggles++;
        end else hb_gap++;
        hb_last = led[3];
    end

    // Hang guard, well beyond the length of all scenarios
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, fault_arm} = '0;
        {awaddr, wdata, araddr} = '0;
        {aresetn, led_watch, hb_seen, hb_last, led_last} = '0;
        {n_fail, check_count, hb_gap, hb_toggles, led_gap} = '0;
        seed = 97;
        app_addr = {2'b01, 22'($random(seed))};
        // Reset values, refusals, then a full boot run
        do_reset();
        axi_rd(`CTRL_OFS, 32'h1, 2'h0);
        axi_wr(`CTRL_OFS, 32'h0, 2'h0);
        led_watch <= 1'b1;
        axi_rd(`STAT_OFS, 32'h0, 2'h0);
        check("updater reset", 32'(upd.rst), 32'h1);
        axi_rd(`ADDR_OFS, 32'h400000, 2'h0);
        axi_rd(`IRQ_MASK_OFS, 32'h0, 2'h0);
        axi_rd(5'h14, 32'h0, 2'h2);
        axi_wr(5'h14, 32'hffffffff, 2'h2);
        axi_wr(`ADDR_OFS, {8'h0, app_addr}, 2'h0);
        axi_wr(`IRQ_MASK_OFS, 32'h7, 2'h0);
        push_run(app_addr);
        axi_wr(`CTRL_OFS, 32'h1, 2'h0);
        for (int i = 0; i < 300 && !upd.reconfig; i++) @(posedge aclk);
        @(posedge aclk);
        check("boot slot", 32'(boot_slot), 32'h1);
        check("boot addr", 32'(boot_addr), 32'(app_addr));
        check("boot irq", 32'(irq), 32'h1);
        check("released", 32'(upd.rst), 32'h0);
        axi_rd(`STAT_OFS, 32'h86, 2'h0);
        axi_rd(`IRQ_STAT_OFS, 32'h1, 2'h0);
        axi_wr(`IRQ_STAT_OFS, 32'h1, 2'h0);
        axi_rd(`IRQ_STAT_OFS, 32'h0, 2'h0);
        check("irq cleared", 32'(irq), 32'h0);
        check("drained", exp_u.size() + exp_led.size(), 0);
        // Reset from the boot state, then a fault after the select flag is written
        do_reset();
        fault_arm <= 1'b1;
        led_watch <= 1'b1;
        exp_u.push_back({3'd4, `PRM_APP_SEL, 24'h1});
        exp_led = {3'd1, 3'd2, 3'd3, 3'd4, 3'd7};
        axi_wr(`IRQ_MASK_OFS, 32'h2, 2'h0);
        for (int i = 0; i < 300 && led[2:0] !== 3'd7; i++) @(posedge aclk);
        fault_arm <= 1'b0;
        t0 = hb_toggles;
        repeat (100) @(posedge aclk);
        check("hold kept", 32'(led[2:0]), 32'h7);
        check("hold trigger", 32'(upd.reconfig), 32'h0);
        check("hold irq", 32'(irq), 32'h1);
        check("hold beat", 32'(hb_toggles - t0 >= 20), 32'h1);
        axi_rd(`STAT_OFS, 32'h27, 2'h0);
        axi_rd(`IRQ_STAT_OFS, 32'h2, 2'h0);
        check("drained", exp_u.size() + exp_led.size(), 0);
        // Application mode: blink, time out, factory run again
        do_reset();
        axi_wr(`IRQ_MASK_OFS, 32'h4, 2'h0);
        axi_wr(`CTRL_OFS, 32'h3, 2'h0);
        {n, bad, flips} = '0;
        prev = led[2:0];
        while (!irq && n < 400) begin
            @(posedge aclk);
            n++;
            if (led[2:0] != 3'd0 && led[2:0] != 3'd7) bad++;
            if (led[2:0] != prev) flips++;
            prev = led[2:0];
        end
        check("blink levels", bad, 0);
        check("blink toggles", 32'(flips > 20), 32'h1);
        check("app time", 32'(n >= TICKS * STEP &&
            n <= TICKS * STEP + STEP + 4), 32'h1);
        for (int i = 0; i < 300 && led[2:0] !== 3'd0; i++) @(posedge aclk);
        push_run(24'h400000);
        led_watch <= 1'b1;
        axi_rd(`CTRL_OFS, 32'h1, 2'h0);
        for (int i = 0; i < 300 && !upd.reconfig; i++) @(posedge aclk);
        @(posedge aclk);
        check("restart slot", 32'(boot_slot), 32'h1);
        check("drained", exp_u.size() + exp_led.size(), 0);
        tally_and_finish();
    end
endmodule
